/* File: common/nvh_pkg.sv */
// Constants shared by the nonvolatile SRAM host controller.
// Assumes a 40 MHz system clock and an asynchronous byte-wide part outside.
`default_nettype none
package nvh_pkg;
    // ========================================================
    // Bus geometry
    localparam int          ADDR_W       = 17;
    localparam int          DATA_W       = 8;
    localparam int          CLK_PERIOD_NS = 25;
    // Address of first clock register byte (top 16 bytes of the map)
    localparam logic [16:0] CLK_REG_BASE = 17'h1fff0;
    // ========================================================
    // Timing, printed figures in ns and derived cycle counts
    localparam int ACCESS_NS   = 45;
    localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
    localparam int STORE_PULSE_NS  = 50;
    localparam int STORE_PULSE_CYC = (STORE_PULSE_NS + CLK_PERIOD_NS - 1) /
                                     CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // ========================================================
    // Sequencer states, Gray coded from idle to done along the access path
    typedef enum logic [2:0] {
        NVH_IDLE   = 3'b000,
        NVH_SETUP  = 3'b001,
        NVH_STROBE = 3'b011,
        NVH_HOLD   = 3'b010,
        NVH_DONE   = 3'b110,
        NVH_PULL   = 3'b111,
        NVH_WAITNV = 3'b101
    } nvh_state_t;
endpackage
`default_nettype wire

/* File: verilog/nvh_host.sv */
// Host controller driving a byte-wide nonvolatile SRAM over its pins.
// Assumes the part's store-busy pin has a pull-up and the bench resolves
// the data and busy wires from the enables given here.
// ========================================================
// Timing of one access, counted in clock edges after the take edge c0
//   c1  chip select low, address and write data launched, ready pulse
//       for a write, write enable falls on this same edge as select
//   c2  read: output enable falls; the bus has one edge to turn round
//   c3  strobe phase continues while the access counter runs out
//   c4  hold phase: write enable rises first, data still driven
//   c5  select rises, response valid, read data captured at this edge
//   c6  back to idle; the next request is taken at c7 at the earliest
// Write enable is released one edge before select and data drive so
// that the part latches stable data with margin on the rising strobe.
//
// Timing of a hardware store
//   s1  the controller starts pulling the busy pin low
//   s3  the pull is released; the part now holds the pin low itself
//   The wait state then runs a minimum count that covers the pulse
//   plus the whole synchroniser and filter latency, so that the low
//   level driven by the part is seen before the wait may end. Without
//   that floor the wait could end before the busy level ever rose.
//   The sequencer leaves the wait only once the filtered busy level is low
//   again, i.e. the part has finished its store.
//
// Limitations
//   Only the pin-triggered store is issued here. Software store and
//   recall sequences are plain accesses to fixed addresses and are up
//   to the user; the controller keeps no record of them.
//   Power-loss saving and power-up restore belong to the part; the
//   controller only sees them as a low busy pin and waits them out.
//   The interrupt pin is not handled by this block.
//
// Bus ownership
//   The data bus is driven by this block only from c1 to c5 of a write.
//   Output enable is never low while the drive enable is high, so a
//   slow part release can only overlap with idle cycles.
//
// Reset
//   Reset is synchronous; all strobes sit high and all enables low
//   while it is held. The filtered busy level starts idle, so a first
//   request may be taken right after release if the pin is high.
//
`default_nettype none
module nvh_host
    import nvh_pkg::*;
#(
    parameter int ACC_CYC = ACCESS_CYC,
    parameter int PUL_CYC = STORE_PULSE_CYC
) (
    input  wire logic              clock,
    input  wire logic              rst,
    // User side
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqData,
    input  wire logic              storeReq,
    output logic                   reqReady,
    output logic                   rspValid,
    output logic [DATA_W-1:0]      rspData,
    output logic                   rspIsClkReg,
    output logic                   nvBusy,
    // Device pins
    output logic [ADDR_W-1:0]      byteAddr,
    input  wire logic [DATA_W-1:0] dataBusIn,
    output logic [DATA_W-1:0]      dataBusOut,
    output logic                   dataBusOe,
    output logic                   chipSel_n,
    output logic                   writeEn_n,
    output logic                   outEn_n,
    input  wire logic              nvStoreBusyIn_n,
    output logic                   nvStoreBusyOut_n,
    output logic                   nvStoreBusyOe
);
    // ========================================================
    // Busy pin synchroniser: three stages, change taken when 2 and 3 agree
    logic       busySync1_reg, busySync2_reg, busySync3_reg;
    logic       busyLevel_reg, busyLevel_next;
    wire  logic busyAgree = (busySync2_reg == busySync3_reg);
    always_ff @(posedge clock) begin
        busySync1_reg <= nvStoreBusyIn_n;
        busySync2_reg <= busySync1_reg;
        busySync3_reg <= busySync2_reg;
    end
    // Filtered level; a single-stage glitch never reaches the sequencer
    assign busyLevel_next = busyAgree ? ~busySync3_reg : busyLevel_reg;
    always_ff @(posedge clock) begin
        if (rst) busyLevel_reg <= 1'b0;
        else     busyLevel_reg <= busyLevel_next;
    end
    // ========================================================
    // Sequencer
    nvh_state_t       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             isWrite_reg;
    wire  logic       cntDone = (cnt_reg == CNT_W'(0));
    wire  logic       accessGo = reqValid && !busyLevel_reg;
    // wait busy clear: no new access while a store or restore runs
    wire  logic       canStart = (state_reg == NVH_IDLE) && !busyLevel_reg;
    // Busy needs three sync stages plus the filter flop to show up
    localparam int    SYNC_LAT = 4;

    function automatic logic [CNT_W-1:0] load(input int n);
        load = CNT_W'(n - 1);
    endfunction

    always_comb begin
        state_next = state_reg;
        cnt_next   = cntDone ? cnt_reg : cnt_reg - CNT_W'(1);
        case (state_reg)
            NVH_IDLE: begin
                if (storeReq && canStart) begin
                    state_next = NVH_PULL;
                    cnt_next   = load(PUL_CYC);
                end else if (accessGo) begin
                    state_next = NVH_SETUP;
                end
            end
            NVH_SETUP: begin
                state_next = NVH_STROBE;
                cnt_next   = load(ACC_CYC);
            end
            NVH_STROBE: if (cntDone) state_next = NVH_HOLD;
            NVH_HOLD:   state_next = NVH_DONE;
            NVH_DONE:   state_next = NVH_IDLE;
            // store pulse: drive busy low for the pulse width
            NVH_PULL:   if (cntDone) state_next = NVH_WAITNV;
            // busy low: wait out the device's own busy
            NVH_WAITNV: if (!busyLevel_reg && cntDone) state_next = NVH_IDLE;
            default:    state_next = NVH_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= NVH_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            // busy low: wait floor covers the synchroniser latency
            cnt_reg   <= (state_reg == NVH_PULL && cntDone)
                         ? load(PUL_CYC + SYNC_LAT) : cnt_next;
        end
    end
    // ========================================================
    // Pin drive decode
    wire logic takeReq  = (state_reg == NVH_IDLE) && (state_next == NVH_SETUP);
    // chip select: low only around the strobe phase
    wire logic selNext  = (state_next == NVH_SETUP) ||
                          (state_next == NVH_STROBE) ||
                          (state_next == NVH_HOLD);
    // write strobe: write enable low, falling on the same edge as chip select
    wire logic wrNext   = (state_next == NVH_SETUP || state_next == NVH_STROBE)
                          && (takeReq ? reqWrite : isWrite_reg);
    // output enable: only for reads, and never together with our drive
    wire logic rdNext   = (state_next == NVH_STROBE || state_next == NVH_HOLD)
                          && !isWrite_reg;
    wire logic sampleRd = (state_reg == NVH_HOLD) && !isWrite_reg;
    // clock window: the top sixteen addresses are the clock registers
    wire logic clkWin   = (byteAddr >= CLK_REG_BASE);
    wire logic pullNext = (state_next == NVH_PULL);

    always_ff @(posedge clock) begin
        if (rst) begin
            isWrite_reg      <= 1'b0;
            byteAddr         <= '0;
            dataBusOut       <= '0;
            dataBusOe        <= 1'b0;
            chipSel_n        <= 1'b1;
            writeEn_n        <= 1'b1;
            outEn_n          <= 1'b1;
            nvStoreBusyOut_n <= 1'b1;
            nvStoreBusyOe    <= 1'b0;
            reqReady         <= 1'b0;
            rspValid         <= 1'b0;
            rspData          <= '0;
            rspIsClkReg      <= 1'b0;
            nvBusy           <= 1'b0;
        end else begin
            if (takeReq) begin
                isWrite_reg <= reqWrite;
                byteAddr    <= reqAddr;
                dataBusOut  <= reqData;
            end
            // shared bus: drive during a write strobe and the hold phase after it
            dataBusOe        <= wrNext ||
                                (state_next == NVH_HOLD && isWrite_reg);
            chipSel_n        <= !selNext;
            writeEn_n        <= !wrNext;
            outEn_n          <= !rdNext;
            nvStoreBusyOut_n <= 1'b0;  // Open-drain: only ever pulls low
            nvStoreBusyOe    <= pullNext;
            reqReady         <= takeReq;
            rspValid         <= (state_reg == NVH_HOLD);
            if (sampleRd) rspData <= dataBusIn;
            if (state_reg == NVH_HOLD) rspIsClkReg <= clkWin;
            nvBusy           <= busyLevel_next || (state_next != NVH_IDLE);
        end
    end
endmodule
`default_nettype wire

/* File: dv/nvh_host_checker.sv */
// Pin-level checks on the nonvolatile SRAM host controller.
// Assumes binding to nvh_host; sees only its ports.
`default_nettype none
module nvh_host_checker #(
    parameter int ACC_CYC = 2,
    parameter int PUL_CYC = 2
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        reqReady,
    input wire logic        rspValid,
    input wire logic        chipSel_n,
    input wire logic        writeEn_n,
    input wire logic        outEn_n,
    input wire logic        dataBusOe,
    input wire logic [16:0] byteAddr,
    input wire logic        nvStoreBusyOe,
    input wire logic        nvStoreBusyOut_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // Access and store sequences
    localparam int RSP_DLY = ACC_CYC + 2;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence take_s; reqReady && !chipSel_n; endsequence
    sequence pull_s; nvStoreBusyOe && chipSel_n; endsequence
    rsp_delay_a: assert property (
        take_s |-> ##RSP_DLY rspValid && chipSel_n)
        else $error("response not on time");
    ready_sel_a: assert property (reqReady |-> take_s)
        else $error("select missing on take");
    write_edge_a: assert property (
        $fell(writeEn_n) |-> $fell(chipSel_n))
        else $error("write strobe not with select");
    write_data_a: assert property (
        !writeEn_n |-> dataBusOe && outEn_n)
        else $error("write without data drive");
    bus_turn_a: assert property (!outEn_n |-> !dataBusOe)
        else $error("bus contention on read");
    addr_hold_a: assert property (
        !chipSel_n && !$past(chipSel_n) |-> $stable(byteAddr))
        else $error("address moved in access");
    store_pull_a: assert property (
        $rose(nvStoreBusyOe) |-> pull_s[*2])
        else $error("store pulse too short");
    pull_low_a: assert property (nvStoreBusyOe |-> !nvStoreBusyOut_n)
        else $error("busy pin driven high");
endmodule
bind nvh_host nvh_host_checker #(.ACC_CYC(ACC_CYC), .PUL_CYC(PUL_CYC)) chk_i (
    .clock, .rst, .reqReady, .rspValid, .chipSel_n, .writeEn_n, .outEn_n,
    .dataBusOe, .byteAddr, .nvStoreBusyOe, .nvStoreBusyOut_n);
`default_nettype wire

/* File: dv/nvh_dev_model.sv */
// Behavioural byte-wide nonvolatile SRAM seen from its pins.
// Assumes the bench resolves the data and busy wires from the enables.
`default_nettype none
module nvh_dev_model
    import nvh_pkg::*;
(
    input  wire logic              clock,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dIn,
    input  wire logic              cs_n,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic              busyPin_n,
    output logic [DATA_W-1:0]      dOut,
    output logic                   dOe,
    output logic                   busyLow
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // array keeps contents over store
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] dLast = 8'h00;
    int                storeCnt = 0;
    // writes gated, store holds busy low
    always @(posedge clock) begin
        if (!cs_n && !we_n && storeCnt == 0) mem[addr] <= dIn;
        if (!busyPin_n && storeCnt == 0) storeCnt <= 8;
        else if (storeCnt > 0) storeCnt <= storeCnt - 1;
        if (dOe) dLast <= dOut;
    end
    assign busyLow = storeCnt != 0;
    // drive only on read; released bus shows inverse, not a stale value
    assign dOe  = !cs_n && !oe_n && storeCnt == 0;
    assign dOut = dOe ? mem[addr] : ~dLast;
endmodule
`default_nettype wire

/* File: dv/tb_nvh_host.sv */
// Self-checking bench for nvh_host against a pin-level device model.
// Assumes a pull-up on the busy pin and nothing else on the bus.
`default_nettype none
module tb_nvh_host
    import nvh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, reqValid = 0, reqWrite = 0, storeReq = 0;
    logic [ADDR_W-1:0] reqAddr = '0, byteAddr;
    logic [DATA_W-1:0] reqData = '0, rspData, dataBusOut, devOut, dataBus;
    logic reqReady, rspValid, rspIsClkReg, nvBusy, dataBusOe, chipSel_n;
    logic writeEn_n, outEn_n, busyOut_n, busyOe, devOe, devBusy;
    int   miscompares = 0, num_checks = 0, cycles = 0;
    // ====================================================
    // Wire resolution: pull-up on busy, host or device on data
    wire busyPin_n = !((busyOe && !busyOut_n) || devBusy);
    assign dataBus = dataBusOe ? dataBusOut : devOut;
    always #12.5 clock = ~clock;
    nvh_host uut (.clock, .rst, .reqValid, .reqWrite, .reqAddr, .reqData,
        .storeReq, .reqReady, .rspValid, .rspData, .rspIsClkReg, .nvBusy,
        .byteAddr, .dataBusIn(dataBus), .dataBusOut, .dataBusOe, .chipSel_n,
        .writeEn_n, .outEn_n, .nvStoreBusyIn_n(busyPin_n),
        .nvStoreBusyOut_n(busyOut_n), .nvStoreBusyOe(busyOe));
    nvh_dev_model dev (.clock, .addr(byteAddr), .dIn(dataBus), .cs_n(chipSel_n),
        .we_n(writeEn_n), .oe_n(outEn_n), .busyPin_n, .dOut(devOut),
        .dOe(devOe), .busyLow(devBusy));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One access, held until taken, then wait for its answer
    task automatic access(input logic wr, input logic [16:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock) #1 {reqValid, reqWrite, reqAddr, reqData} = {1'b1, wr, a, d};
        while (!reqReady && n < 60) begin @(posedge clock) #1 n++; end
        reqValid = 0;
        while (!rspValid && n < 60) begin @(posedge clock) #1 n++; end
        chk(8'(n < 60), 8'h01);
    endtask
    // Array ends and clock window ends, written then read back
    task automatic t_rw;
        logic [16:0] a [4] = '{17'h00000, 17'h1ffef, 17'h1fff0, 17'h1ffff};
        for (int i = 0; i < 4; i++) access(1'b1, a[i], 8'h5a + 8'(i));
        for (int i = 0; i < 4; i++) begin
            access(1'b0, a[i], 8'h00);
            chk(rspData, 8'h5a + 8'(i));
            chk(8'(rspIsClkReg), 8'(a[i] >= CLK_REG_BASE));
        end
        $display("t_rw done");
    endtask
    // Store pulse, request refused while busy, contents kept after
    task automatic t_store;
        int n, taken;
        {n, taken} = 0;
        @(posedge clock) #1 storeReq = 1;
        @(posedge clock) #1 {storeReq, reqValid, reqAddr} = {2'b01, 17'h0};
        while (busyPin_n && n < 20) begin @(posedge clock) #1 n++; end
        chk(8'(busyPin_n), 8'h00);
        chk(8'(nvBusy), 8'h01);
        while (!busyPin_n && n < 60) begin @(posedge clock) #1 taken += reqReady; n++; end
        chk(8'(taken), 8'h00);
        reqValid = 0;
        repeat (8) @(posedge clock);
        access(1'b0, 17'h00000, 8'h00);
        chk(rspData, 8'h5a);
        $display("t_store done");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // no contention: part and host never drive the bus together
    always @(posedge clock) begin
        if (!rst && devOe && dataBusOe) begin
            miscompares++;
            $display("[ERR] %0t bus driven by both sides", $time);
        end
    end
    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin miscompares++; close_out; end
    end
    initial begin
        repeat (10) @(posedge clock);
        #1 rst = 0;
        t_rw;
        t_store;
        close_out;
    end
endmodule
`default_nettype wire
